// [hw/qfc_top.sv]
// device-side flash sequencer: continuous quad read, burst wrap, erase decode, program
// assumes: host pins are asynchronous; the array sits behind the
// read fifo and the erase / program strobes, on ref_clk_in
//
// Behaviour
// RULE1: continuous mode needs quad enable and continuous read enable both set.
// RULE2: continuous mode only for EBh/E7h; first transfer 1-4-4, later ones 0-4-4.
// RULE3: E7h reads from a double-word aligned address; EBh takes any address.
// RULE4: host drives all mode bits, preferably 55h or FFh outside continuous mode.
// RULE5: mode byte follows address; bits 5:4 equal to 10 enter continuous mode.
// RULE6: initial transfer: opcode on one line, 24-bit address in six quad clocks.
// RULE7: in continuous mode each transaction carries only address and mode byte.
// RULE8: chip select high stops output; next selection takes a new address.
// RULE9: mode byte re-decoded each transfer; not 10 finishes read then leaves mode.
// RULE10: in 0-4-4 mode only the active EBh or E7h read executes.
// RULE11: host leaves continuous mode before sending 77h.
// RULE12: 77h carries eight wrap bits; bits 6:4 pick 8 to 64 byte wrap.
// RULE13: 77h only updates wrap setting, never touches the array.
// RULE14: 77h uses 1-4-4: opcode on one line, address and wrap on four.
// RULE15: D8h erases 64 kB block from address bits 19:16.
// RULE16: 52h erases 32 kB block from address bits 19:15.
// RULE17: 20h erases 4 kB block from address bits 19:12.
// RULE18: supports page or partial program and chip or block erase.
// RULE19: input latched on rising sclk, output changed on falling sclk.
// RULE20: after address and mode, device drives four bits per clock on all lines.
// RULE21: after leaving continuous mode, next transaction opens with an opcode.
`timescale 1ns/1ps

module qfc_top
  import qfc_pkg::*;
(
  input wire logic ref_clk_in,               // 50 MHz system clock
  input wire logic arst_n_in,                // async reset, active low
  input wire logic cs_n_in,                  // host chip select, active low
  input wire logic sclk_in,                  // host serial clock
  input wire logic [3:0] io_in,              // data pins, input side
  output logic [3:0] io_out,                 // data pins, output side
  output logic [3:0] io_oe_n_out,            // data pin enables, low drives
  input wire logic [7:0] status1_in,         // first status register
  input wire logic [7:0] status4_in,         // fourth status register
  output logic cont_mode_out,                // continuous read mode active
  output logic [7:0] wrap_setting_out,       // burst wrap byte
  output qfc_rd_req_s rd_req_out,            // read start address and wrap
  output logic rd_req_valid_out,             // read start pulse
  input wire logic [7:0] mem_data_in,        // array read byte
  input wire logic mem_valid_in,             // array read byte valid
  output logic mem_ready_out,                // fifo has room
  output qfc_erase_s erase_out,              // erase kind and block
  output logic erase_valid_out,              // erase pulse
  output qfc_prog_s prog_out,                // program address and byte
  output logic prog_valid_out                // program byte pulse
);

  // ************************************************************
  // reset release and pin sampling
  // ************************************************************
  logic [1:0] rst_pipe;
  wire rst_n = rst_pipe[1];

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  logic [5:0] pins;
  qfc_sync #(.WIDTH(6), .RST(6'h20)) u_sync (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .d_in({cs_n_in, sclk_in, io_in}),
    .q_out(pins)
  );

  wire cs_n_lvl = pins[5];
  wire sclk_lvl = pins[4];
  wire [3:0] io_lvl = pins[3:0];

  logic cs_n_q;
  logic sclk_q;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_lvl;
      sclk_q <= sclk_lvl;
    end
  end

  wire cs_fall = cs_n_q && !cs_n_lvl;
  wire cs_rise = !cs_n_q && cs_n_lvl;
  wire selected = !cs_n_lvl && !cs_n_q;
  wire sclk_rise = selected && sclk_lvl && !sclk_q; // RULE19
  wire sclk_fall = selected && !sclk_lvl && sclk_q; // RULE19

  // ************************************************************
  // registers and decode wires
  // ************************************************************
  qfc_state_e state;
  qfc_state_e next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [23:0] shreg;
  logic [23:0] next_shreg;
  logic [7:0] op;
  logic [7:0] next_op;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic cont;
  logic next_cont;
  logic cont_pend;
  logic next_cont_pend;
  logic [7:0] wrap;
  logic [7:0] next_wrap;
  logic [3:0] oe_n;
  logic [3:0] next_oe_n;
  logic [3:0] dout;
  logic [3:0] next_dout;
  logic lo_nib;
  logic next_lo_nib;
  logic rd_v;
  logic next_rd_v;
  qfc_rd_req_s rd_req;
  qfc_rd_req_s next_rd_req;
  logic er_v;
  logic next_er_v;
  qfc_erase_s er;
  qfc_erase_s next_er;
  logic pg_v;
  logic next_pg_v;
  qfc_prog_s pg;
  qfc_prog_s next_pg;
  logic pop;

  wire quad_enable_bit = status1_in[SR1_QUAD_ENABLE_POS];
  wire continuous_read_enable = status4_in[SR4_CONT_READ_POS];
  wire cont_allowed = quad_enable_bit && continuous_read_enable; // RULE1

  wire [7:0] op_shift = {shreg[6:0], io_lvl[0]};
  wire [23:0] qaddr_shift = {shreg[19:0], io_lvl};
  wire [7:0] qbyte_shift = {shreg[3:0], io_lvl};
  wire [23:0] saddr_shift = {shreg[22:0], io_lvl[0]};
  wire [1:0] mode_sel = qbyte_shift[MODE_SEL_HI:MODE_SEL_LO];
  wire is_qread = (op == OP_QREAD) || (op == OP_QREAD_DW); // RULE2
  // E7h forces a double-word start
  wire [23:0] read_addr = (op == OP_QREAD_DW) ? {addr[23:DWORD_ALIGN_BITS], {DWORD_ALIGN_BITS{1'b0}}} : addr; // RULE3
  wire [7:0] blk64 = 8'(addr[BLK64_HI:BLK64_LO]); // RULE15
  wire [7:0] blk32 = 8'(addr[BLK32_HI:BLK32_LO]); // RULE16
  wire [7:0] blk4 = addr[BLK4_HI:BLK4_LO]; // RULE17
  wire is_erase_op = (op == OP_ERASE_64K) || (op == OP_ERASE_32K) || (op == OP_ERASE_4K);
  wire is_chip_erase = (op == OP_ERASE_CHIP_A) || (op == OP_ERASE_CHIP_B);

  // ************************************************************
  // read data fifo
  // ************************************************************
  wire [7:0] fifo_data;
  wire fifo_valid;

  // flushing on chip select high keeps stale bytes out of the next burst
  qfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .flush_in(cs_rise),
    .in_data_in(mem_data_in),
    .in_valid_in(mem_valid_in),
    .in_ready_out(mem_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop)
  );

  // ************************************************************
  // transfer sequencer
  // ************************************************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_op = op;
    next_addr = addr;
    next_cont = cont;
    next_cont_pend = cont_pend;
    next_wrap = wrap;
    next_oe_n = oe_n;
    next_dout = dout;
    next_lo_nib = lo_nib;
    next_rd_v = 1'b0;
    next_rd_req = rd_req;
    next_er_v = 1'b0;
    next_er = er;
    next_pg_v = 1'b0;
    next_pg = pg;
    pop = 1'b0;
    if (cs_rise) begin
      next_state = ST_IDLE;
      next_oe_n = OE_N_RELEASED; // RULE8
      if (state == ST_QDATA) begin
        next_cont = cont_pend; // RULE9
      end
      // a cut erase command is dropped
      if (state == ST_HALT && (is_erase_op || is_chip_erase) && !cont) begin
        next_er_v = 1'b1; // RULE18
        next_er.kind = ER_CHIP;
        next_er.block = 8'h00;
        if (op == OP_ERASE_64K) begin
          next_er.kind = ER_64K;
          next_er.block = blk64; // RULE15
        end else if (op == OP_ERASE_32K) begin
          next_er.kind = ER_32K;
          next_er.block = blk32; // RULE16
        end else if (op == OP_ERASE_4K) begin
          next_er.kind = ER_4K;
          next_er.block = blk4; // RULE17
        end
      end
    end else if (cs_fall) begin
      next_cnt = 5'h00;
      next_lo_nib = 1'b0;
      // continuous: reuse the held read opcode
      next_state = cont ? ST_QADDR : ST_CMD; // RULE7 RULE10 RULE21
    end else if (sclk_rise) begin
      next_cnt = cnt + 5'h01;
      case (state)
        ST_CMD: begin
          next_shreg = {16'h0000, op_shift};
          if (cnt == CMD_CLOCKS - 5'h01) begin
            next_op = op_shift;
            next_cnt = 5'h00;
            if ((op_shift == OP_QREAD || op_shift == OP_QREAD_DW) && quad_enable_bit) begin
              next_state = ST_QADDR; // RULE2 RULE6
            end else if (op_shift == OP_SET_WRAP) begin
              next_state = ST_QADDR; // RULE14
            end else if (op_shift == OP_ERASE_64K || op_shift == OP_ERASE_32K || op_shift == OP_ERASE_4K ||
                         op_shift == OP_PROGRAM) begin
              next_state = ST_SADDR;
            end else begin
              next_state = ST_HALT;
            end
          end
        end
        ST_QADDR: begin
          next_shreg = qaddr_shift;
          if (cnt == QADDR_CLOCKS - 5'h01) begin
            next_addr = qaddr_shift; // RULE6
            next_cnt = 5'h00;
            next_state = ST_QMODE;
          end
        end
        ST_QMODE: begin
          next_shreg = {16'h0000, qbyte_shift};
          if (cnt == QMODE_CLOCKS - 5'h01) begin
            next_cnt = 5'h00;
            if (op == OP_SET_WRAP) begin
              // wrap byte only: nothing reaches the array
              next_wrap = qbyte_shift; // RULE12 RULE13
              next_state = ST_HALT;
            end else begin
              next_cont_pend = is_qread && cont_allowed && (mode_sel == MODE_SEL_CONT); // RULE5 RULE1 RULE9
              next_rd_v = 1'b1;
              next_rd_req.addr = read_addr; // RULE3
              next_rd_req.wrap = wrap;
              next_oe_n = OE_N_DRIVEN; // RULE20
              next_lo_nib = 1'b0;
              next_state = ST_QDATA;
            end
          end
        end
        ST_SADDR: begin
          next_shreg = saddr_shift;
          if (cnt == SADDR_CLOCKS - 5'h01) begin
            next_addr = saddr_shift;
            next_cnt = 5'h00;
            next_state = (op == OP_PROGRAM) ? ST_SDATA : ST_HALT;
          end
        end
        ST_SDATA: begin
          next_shreg = {16'h0000, op_shift};
          if (cnt == SBYTE_CLOCKS - 5'h01) begin
            next_cnt = 5'h00;
            next_pg_v = 1'b1; // RULE18
            next_pg.addr = addr;
            next_pg.data = op_shift;
            // column wraps inside the 256-byte page
            next_addr = {addr[23:8], addr[7:0] + 8'h01};
          end
        end
        default: begin
          next_cnt = cnt;
        end
      endcase
    end else if (sclk_fall && state == ST_QDATA) begin
      // empty fifo repeats the nibble: the array must keep ahead
      if (fifo_valid) begin
        next_dout = lo_nib ? fifo_data[3:0] : fifo_data[7:4]; // RULE20 RULE19
        next_lo_nib = !lo_nib;
        pop = lo_nib;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 5'h00;
      shreg <= 24'h000000;
      op <= 8'h00;
      addr <= 24'h000000;
      cont <= 1'b0;
      cont_pend <= 1'b0;
      wrap <= WRAP_RESET;
      oe_n <= OE_N_RELEASED;
      dout <= 4'h0;
      lo_nib <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      op <= next_op;
      addr <= next_addr;
      cont <= next_cont;
      cont_pend <= next_cont_pend;
      wrap <= next_wrap;
      oe_n <= next_oe_n;
      dout <= next_dout;
      lo_nib <= next_lo_nib;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_v <= 1'b0;
      rd_req <= '0;
      er_v <= 1'b0;
      er <= '0;
      pg_v <= 1'b0;
      pg <= '0;
    end else begin
      rd_v <= next_rd_v;
      rd_req <= next_rd_req;
      er_v <= next_er_v;
      er <= next_er;
      pg_v <= next_pg_v;
      pg <= next_pg;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign io_out = dout;
  assign io_oe_n_out = oe_n;
  assign cont_mode_out = cont;
  assign wrap_setting_out = wrap;
  assign rd_req_out = rd_req;
  assign rd_req_valid_out = rd_v;
  assign erase_out = er;
  assign erase_valid_out = er_v;
  assign prog_out = pg;
  assign prog_valid_out = pg_v;

endmodule

// [shared/qfc_pkg.sv]
// constants and carrier types of the quad flash sequencer
// assumes: one system clock domain samples the serial pins

package qfc_pkg;

  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [7:0] OP_QREAD = 8'hEB;
  localparam logic [7:0] OP_QREAD_DW = 8'hE7;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
  localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
  localparam logic [7:0] OP_PROGRAM = 8'h02;

  // ************************************************************
  // status bit positions and mode byte fields
  // ************************************************************
  localparam int SR1_QUAD_ENABLE_POS = 2;
  localparam int SR4_CONT_READ_POS = 3;
  localparam int MODE_SEL_HI = 5;
  localparam int MODE_SEL_LO = 4;
  localparam logic [1:0] MODE_SEL_CONT = 2'b10;
  localparam int WRAP_LEN_HI = 6;
  localparam int WRAP_LEN_LO = 4;

  // ************************************************************
  // block address fields
  // ************************************************************
  localparam int BLK64_HI = 19;
  localparam int BLK64_LO = 16;
  localparam int BLK32_HI = 19;
  localparam int BLK32_LO = 15;
  localparam int BLK4_HI = 19;
  localparam int BLK4_LO = 12;
  localparam int DWORD_ALIGN_BITS = 2;

  // ************************************************************
  // transfer lengths in serial clocks
  // ************************************************************
  localparam logic [4:0] CMD_CLOCKS = 5'h08;
  localparam logic [4:0] QADDR_CLOCKS = 5'h06;
  localparam logic [4:0] QMODE_CLOCKS = 5'h02;
  localparam logic [4:0] SADDR_CLOCKS = 5'h18;
  localparam logic [4:0] SBYTE_CLOCKS = 5'h08;

  // ************************************************************
  // reset values, pin enable codes and fifo depth
  // ************************************************************
  localparam logic [7:0] WRAP_RESET = 8'hFF;
  localparam logic [3:0] OE_N_RELEASED = 4'hF;
  localparam logic [3:0] OE_N_DRIVEN = 4'h0;
  localparam int FIFO_DEPTH = 4;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_QADDR = 3'b010,
    ST_QMODE = 3'b011,
    ST_QDATA = 3'b100,
    ST_SADDR = 3'b101,
    ST_SDATA = 3'b110,
    ST_HALT = 3'b111
  } qfc_state_e;

  typedef enum logic [1:0] {
    ER_CHIP = 2'b00,
    ER_4K = 2'b01,
    ER_32K = 2'b10,
    ER_64K = 2'b11
  } qfc_erase_e;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wrap;
  } qfc_rd_req_s;

  typedef struct packed {
    qfc_erase_e kind;
    logic [7:0] block;
  } qfc_erase_s;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } qfc_prog_s;

endpackage

// [hw/qfc_sync.sv]
// three-stage pin synchroniser with agreement filter
// assumes: inputs asynchronous to clk_in; stages two and three must agree
`timescale 1ns/1ps

module qfc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic clk_in,              // system clock
  input wire logic rst_n_in,            // synchronous-release reset
  input wire logic [WIDTH-1:0] d_in,    // raw pin levels
  output logic [WIDTH-1:0] q_out        // filtered levels
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      // s1 feeds only s2 to keep the metastable stage isolated
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          s1 <= RST[i];
          s2 <= RST[i];
          s3 <= RST[i];
          lvl <= RST[i];
        end else begin
          s1 <= d_in[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            lvl <= s3;
          end
        end
      end
      assign q_out[i] = lvl;
    end
  endgenerate

endmodule

// [hw/qfc_fifo.sv]
// small synchronous fifo with valid/ready on both sides and a flush
// assumes: single clock; flush drops every stored word in one cycle
`timescale 1ns/1ps

module qfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,              // system clock
  input wire logic rst_n_in,            // reset, active low
  input wire logic flush_in,            // drop contents
  input wire logic [WIDTH-1:0] in_data_in,  // fill data
  input wire logic in_valid_in,         // fill valid
  output logic in_ready_out,            // not full
  output logic [WIDTH-1:0] out_data_out,    // head word
  output logic out_valid_out,           // not empty
  input wire logic out_ready_in         // drain accept
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire do_push = in_valid_in && in_ready_out;
  wire do_pop = out_valid_out && out_ready_in;
  wire [AW-1:0] wr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] rd_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign in_ready_out = (count != CNT_FULL);
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= do_push ? wr_inc : wr_ptr;
      rd_ptr <= do_pop ? rd_inc : rd_ptr;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule

// [test/qfc_checker.sv]
// port checks for the quad flash sequencer
// assumes: bound into qfc_top; one clock domain, reset active low
`timescale 1ns/1ps

module qfc_checker
  import qfc_pkg::*;
(
  input wire logic ref_clk_in, // clock
  input wire logic arst_n_in, // reset
  input wire logic cs_n_in, // select
  input wire logic sclk_in, // sclk
  input wire logic [3:0] io_in, // pins
  input wire logic [3:0] io_out, // drive
  input wire logic [3:0] io_oe_n_out, // enables
  input wire logic [7:0] status1_in, // status 1
  input wire logic [7:0] status4_in, // status 4
  input wire logic cont_mode_out, // mode
  input wire logic [7:0] wrap_setting_out, // wrap
  input wire qfc_rd_req_s rd_req_out, // request
  input wire logic rd_req_valid_out, // request pulse
  input wire logic [7:0] mem_data_in, // byte
  input wire logic mem_valid_in, // byte valid
  input wire logic mem_ready_out, // room
  input wire qfc_erase_s erase_out, // erase
  input wire logic erase_valid_out, // erase pulse
  input wire qfc_prog_s prog_out, // program
  input wire logic prog_valid_out // program pulse
);
  // ************************************************************
  // relations at the ports
  // ************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  AST_OE_PAIR: assert property (io_oe_n_out == OE_N_RELEASED || io_oe_n_out == OE_N_DRIVEN)
    else $error("pin enables split");
  AST_OE_IDLE: assert property (cs_n_in [*8] |-> io_oe_n_out == OE_N_RELEASED)
    else $error("pins driven while deselected");
  AST_RD_OE: assert property (rd_req_valid_out |-> ##[0:8] io_oe_n_out == OE_N_DRIVEN)
    else $error("read without turnaround");
  AST_RD_PULSE: assert property (rd_req_valid_out |=> !rd_req_valid_out)
    else $error("read pulse too long");
  AST_RD_CS: assert property (rd_req_valid_out |-> !cs_n_in)
    else $error("read outside a transaction");
  AST_CONT_EN: assert property ($rose(cont_mode_out) |->
    status1_in[SR1_QUAD_ENABLE_POS] && status4_in[SR4_CONT_READ_POS]) else $error("mode entered while disabled");
  AST_CONT_CS: assert property ($changed(cont_mode_out) |-> cs_n_in)
    else $error("mode changed mid transaction");
  AST_WRAP_ONLY: assert property ($changed(wrap_setting_out) |->
    !cs_n_in && !erase_valid_out && !prog_valid_out && !rd_req_valid_out) else $error("wrap update touched array");
  AST_ERASE_CS: assert property (erase_valid_out |-> cs_n_in)
    else $error("erase before deselect");
  cover property (rd_req_valid_out);
  cover property ($rose(cont_mode_out));
  cover property (erase_valid_out);
endmodule

bind qfc_top qfc_checker qfc_checker_inst (.*);

// [test/qfc_host.sv]
// host quad spi controller model: chip select, serial clock, data pins
// assumes: mode 0, each serial half period is four system clocks
`timescale 1ns/1ps

module qfc_host (
  input wire logic clk_in, // system clock
  input wire logic [3:0] pin_in, // resolved pins
  output logic cs_n_out, // chip select
  output logic sclk_out, // serial clock, idles low
  output logic [3:0] io_out // host drive
);
  logic [7:0] smp = 8'h00;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_out = 4'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // ************************************************************
  // link cycles
  // ************************************************************
  // data moves while sclk is low; sampled late in the high phase
  task automatic tick(input logic [3:0] v);
    io_out <= v;
    wt(4);
    sclk_out <= 1'b1;
    wt(4);
    smp = {smp[3:0], pin_in};
    sclk_out <= 1'b0;
  endtask
  task automatic start();
    cs_n_out <= 1'b0;
    wt(4);
  endtask
  task automatic ser(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) tick({~b[i], ~b[i], ~b[i], b[i]});
  endtask
  // all mode bits driven
  task automatic quad(input logic [31:0] v);
    for (int i = 7; i >= 0; i--) tick(v[4*i+:4]);
  endtask
  task automatic stop();
    wt(4);
    cs_n_out <= 1'b1;
    io_out <= ~io_out;
    wt(16);
  endtask
endmodule

// [test/tb_quad_flash_continuous_read.sv]
// self-checking bench of the quad flash sequencer with host and array models
// assumes: package, design, host model and checker compiled first
`timescale 1ns/1ps

module tb_quad_flash_continuous_read;
  import qfc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sclk, cont, rqv, mrdy, erv, pgv;
  logic [3:0] hio, dio, oe_n;
  logic [7:0] wrap;
  logic [7:0] st1 = 8'h00;
  logic [7:0] st4 = 8'h00;
  logic [7:0] mptr = 8'h00;
  logic mval = 1'b0;
  qfc_rd_req_s rq;
  qfc_erase_s er;
  qfc_prog_s pg;
  logic [31:0] rq_q[$];
  logic [9:0] er_q[$];
  logic [31:0] pg_q[$];
  logic [31:0] seed = 32'h06AC5E67;
  logic [7:0] m_op = 8'h00;
  logic [7:0] m_wrap = WRAP_RESET;
  bit m_cont = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  // each pin shows the device where its enable is low, else the host
  wire logic [3:0] pins = (~oe_n & dio) | (oe_n & hio);

  initial forever #10 clk = ~clk;
  qfc_top qfc_top_inst (.ref_clk_in(clk), .arst_n_in(rst_n), .cs_n_in(cs_n), .sclk_in(sclk), .io_in(pins),
    .io_out(dio), .io_oe_n_out(oe_n), .status1_in(st1), .status4_in(st4), .cont_mode_out(cont),
    .wrap_setting_out(wrap), .rd_req_out(rq), .rd_req_valid_out(rqv), .mem_data_in(mptr),
    .mem_valid_in(mval), .mem_ready_out(mrdy), .erase_out(er), .erase_valid_out(erv), .prog_out(pg),
    .prog_valid_out(pgv));
  qfc_host qfc_host_inst (.clk_in(clk), .pin_in(pins), .cs_n_out(cs_n), .sclk_out(sclk), .io_out(hio));

  // ************************************************************
  // array model: bytes count up from the requested address
  // ************************************************************
  always @(posedge clk) begin
    if (rqv) begin
      rq_q.push_back(rq);
      mptr <= rq.addr[7:0];
      mval <= 1'b1;
    end else if (cs_n) begin
      mval <= 1'b0;
    end else if (mval && mrdy) begin
      mptr <= mptr + 8'h01;
    end
    if (erv) er_q.push_back(er);
    if (pgv) pg_q.push_back(pg);
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic set_st(input bit qe, input bit ce);
    seed = nx(seed);
    st1 <= {seed[7:3], qe, seed[1:0]};
    st4 <= {seed[15:12], ce, seed[10:8]};
    @(posedge clk);
  endtask
  // quad transfer: read, continuation or wrap setting
  task automatic xfer(input logic [7:0] op, input logic [7:0] m, input bit cmd);
    logic [23:0] ea;
    bit wr;
    bit ok;
    seed = nx(seed);
    wr = cmd && op == OP_SET_WRAP;
    if (cmd) m_op = op;
    ok = !wr && (cmd ? st1[SR1_QUAD_ENABLE_POS] : m_cont);
    ea = (m_op == OP_QREAD_DW) ? {seed[23:2], 2'b00} : seed[23:0];
    qfc_host_inst.start();
    if (cmd) qfc_host_inst.ser(op);
    qfc_host_inst.quad({seed[23:0], m});
    for (int i = 0; i < 2 && ok; i++) begin
      qfc_host_inst.tick(~hio);
      qfc_host_inst.tick(~hio);
      chk(32'(qfc_host_inst.smp), 32'(8'(ea[7:0] + i)));
    end
    qfc_host_inst.stop();
    if (wr) m_wrap = m;
    chk(32'(mrdy), 32'h1);
    chk(32'(rq_q.size()), 32'(ok));
    if (ok) chk(rq_q.pop_front(), {ea, m_wrap});
    m_cont = ok && m[5:4] == MODE_SEL_CONT && st1[SR1_QUAD_ENABLE_POS] && st4[SR4_CONT_READ_POS];
    chk(32'(cont), 32'(m_cont));
    chk(32'(wrap), 32'(m_wrap));
  endtask
  task automatic xser(input logic [7:0] op);
    logic [9:0] ee;
    seed = nx(seed);
    case (op)
      OP_ERASE_64K: ee = {ER_64K, 4'h0, seed[19:16]};
      OP_ERASE_32K: ee = {ER_32K, 3'h0, seed[19:15]};
      OP_ERASE_4K: ee = {ER_4K, seed[19:12]};
      default: ee = {ER_CHIP, 8'h00};
    endcase
    qfc_host_inst.start();
    qfc_host_inst.ser(op);
    if (ee[9:8] != ER_CHIP || op == OP_PROGRAM) for (int i = 2; i >= 0; i--) qfc_host_inst.ser(seed[8*i+:8]);
    if (op == OP_PROGRAM) qfc_host_inst.ser(seed[31:24]);
    qfc_host_inst.stop();
    chk(32'(er_q.size() + pg_q.size()), 32'h1);
    if (op == OP_PROGRAM) chk(pg_q.pop_front(), {seed[23:0], seed[31:24]});
    else chk(32'(er_q.pop_front()), 32'(ee));
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(wrap), 32'(WRAP_RESET));
    chk(32'(oe_n), 32'(OE_N_RELEASED));
    set_st(1'b1, 1'b1);
    xfer(OP_SET_WRAP, seed[31:24], 1'b1);
    xfer(OP_QREAD, 8'h20, 1'b1);
    xfer(8'h00, 8'hA0, 1'b0);
    xfer(8'h00, 8'hFF, 1'b0);
    xser(OP_ERASE_64K);
    xser(OP_ERASE_32K);
    xser(OP_ERASE_4K);
    xser(OP_ERASE_CHIP_A);
    xser(OP_ERASE_CHIP_B);
    xser(OP_PROGRAM);
    xfer(OP_QREAD_DW, 8'h20, 1'b1);
    xfer(8'h00, 8'h10, 1'b0);
    xfer(OP_SET_WRAP, seed[31:24], 1'b1);
    set_st(1'b1, 1'b0);
    xfer(OP_QREAD, 8'h20, 1'b1);
    set_st(1'b0, 1'b1);
    xfer(OP_QREAD, 8'h20, 1'b1);
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule
